// >>> shared/oit_pkg.sv
/*
 * shared constants and carrier types for the session countdown timer:
 * command codes, register field layout, reset values and tick timing.
 * assumes a single 200 mhz clock domain shared by timer and host logic.
 */
package oit_pkg;

    // command codes issued by the host processor
    localparam logic [7:0] CODE_CTRL_RD = 8'h6a;
    localparam logic [7:0] CODE_CTRL_WR = 8'hea;
    localparam logic [7:0] CODE_ALT_RD = 8'h6c;
    localparam logic [7:0] CODE_ALT_WR = 8'hec;

    // register widths and field layout
    localparam int DATA_W = 32;
    localparam int RUN_BIT = 31;
    localparam int PRELOAD_W = 24;
    localparam int PRELOAD_LSB = 0;
    localparam int PRELOAD_MSB = PRELOAD_LSB + PRELOAD_W - 1;
    localparam int RSVD_W = RUN_BIT - PRELOAD_MSB - 1;

    // bit of the neighbouring interrupt enable register we mirror
    localparam int IRQ_EN_BIT = 10;

    // reset values
    localparam logic [PRELOAD_W-1:0] PRELOAD_RST = 24'h000000;
    localparam logic [DATA_W-1:0] ALT_RST = 32'h00000000;
    localparam logic [DATA_W-1:0] RD_IDLE = 32'h00000000;

    // tick timing: 0.01 ms per preload unit at a 5 ns clock
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TICK_PERIOD_PS = 10000000;
    localparam int TICK_CYCLES = TICK_PERIOD_PS / CLK_PERIOD_PS;
    localparam int TICK_CNT_W = $clog2(TICK_CYCLES);
    localparam logic [TICK_CNT_W-1:0] TICK_LAST =
        TICK_CNT_W'(TICK_CYCLES - 1);

    // longest interval with a full preload, in milliseconds
    localparam longint MAX_INTERVAL_MS = 167772;

    // one host command, presented for a single cycle
    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [DATA_W-1:0] data;
    } oit_cmd_s;

    // read answer returned to the host
    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } oit_rsp_s;

endpackage : oit_pkg

// >>> core/oit_tick_gen.sv
/*
 * divides the system clock down to the 0.01 ms countdown tick.
 * assumes i_restart is a same-clock pulse that realigns the tick phase.
 */
`timescale 1ns/100ps
`default_nettype none

module oit_tick_gen (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // control
    input wire logic i_restart,
    // tick out
    output logic o_tick
);

    logic [oit_pkg::TICK_CNT_W-1:0] div_q;
    logic [oit_pkg::TICK_CNT_W-1:0] div_d;
    logic tick_q;
    logic tick_d;

    // divider next state; restart realigns the phase
    always_comb begin
        div_d = div_q + oit_pkg::TICK_CNT_W'(1);
        tick_d = 1'b0;
        if (i_restart) begin
            div_d = '0;
        end else if (div_q == oit_pkg::TICK_LAST) begin
            div_d = '0;
            tick_d = 1'b1; // see [RULE10]
        end
    end

    // divider registers
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    assign o_tick = tick_q;

endmodule : oit_tick_gen

`default_nettype wire

// >>> core/oit_interval_timer.sv
/*
 * session countdown timer: control register, alternate register and
 * the 24-bit down counter clocked by the 0.01 ms tick.
 * assumes host commands and the irq enable come from same-clock logic,
 * and that the neighbouring interrupt block latches the expiry pulse.
 * one clock domain throughout, so no input needs a synchroniser.
 */
// How it works
// [RULE1] control register read with code 6a, written with code ea.
// [RULE2] writing run bit 31 as one loads preload and starts counting.
// [RULE3] writing run bit as zero halts the count; no expiry follows.
// [RULE4] on expiry the run bit clears itself; reads show timer stopped.
// [RULE5] preload sits in bits 23..0, resets to zero, read and write.
// [RULE6] one preload unit equals one 0.01 ms tick.
// [RULE7] full 24-bit preload gives the longest interval, 167.772 s.
// [RULE8] alternate register read with code 6c, written with code ec.
// [RULE9] expiry raises the interrupt only while enable bit 10 is set.
// [RULE10] tick derived from the clock; expiry after exactly preload ticks.
`timescale 1ns/100ps
`default_nettype none

module oit_interval_timer (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // host command port
    input wire oit_pkg::oit_cmd_s i_cmd,
    output oit_pkg::oit_rsp_s o_rsp,
    // neighbouring interrupt enable register, whole word
    input wire logic [oit_pkg::DATA_W-1:0] i_irq_enable_reg,
    // timer status
    output logic o_running,
    output logic [oit_pkg::PRELOAD_W-1:0] o_count,
    output logic o_expired,
    output logic o_expiry_irq
);

    // true when a valid command carries the given code
    function automatic logic cmd_is(input oit_pkg::oit_cmd_s cmd,
                                    input logic [7:0] code);
        cmd_is = cmd.valid && (cmd.code == code);
    endfunction : cmd_is

    // preload field of a written control word
    function automatic logic [oit_pkg::PRELOAD_W-1:0] preload_of(
        input logic [oit_pkg::DATA_W-1:0] data);
        preload_of = data[oit_pkg::PRELOAD_MSB:oit_pkg::PRELOAD_LSB];
    endfunction : preload_of

    // decoded command strobes; a control write either starts or
    // stops the timer, never neither
    logic ctrl_wr;
    logic ctrl_rd;
    logic alt_wr;
    logic alt_rd;
    logic wr_run;
    logic start;
    logic stop;

    assign ctrl_wr = cmd_is(i_cmd, oit_pkg::CODE_CTRL_WR); // see [RULE1]
    assign ctrl_rd = cmd_is(i_cmd, oit_pkg::CODE_CTRL_RD); // see [RULE1]
    assign alt_wr = cmd_is(i_cmd, oit_pkg::CODE_ALT_WR); // see [RULE8]
    assign alt_rd = cmd_is(i_cmd, oit_pkg::CODE_ALT_RD); // see [RULE8]
    assign wr_run = i_cmd.data[oit_pkg::RUN_BIT];
    assign start = ctrl_wr && wr_run;
    assign stop = ctrl_wr && !wr_run;

    // tick source, realigned on every start so the interval is exact;
    // without it the first tick could land up to a whole period early
    logic tick;

    oit_tick_gen u_tick (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_restart(start),
        .o_tick(tick)
    );

    // register state; the alternate word is a plain store that
    // has no effect on counting
    logic countdown_run_bit_q;
    logic countdown_run_bit_d;
    logic [oit_pkg::PRELOAD_W-1:0] countdown_preload_q;
    logic [oit_pkg::PRELOAD_W-1:0] countdown_preload_d;
    logic [oit_pkg::DATA_W-1:0] alternate_session_countdown_q;
    logic [oit_pkg::DATA_W-1:0] alternate_session_countdown_d;

    // counter state
    logic [oit_pkg::PRELOAD_W-1:0] count_q;
    logic [oit_pkg::PRELOAD_W-1:0] count_d;
    logic expire;
    logic expired_q;
    logic expired_d;
    logic irq_q;
    logic irq_d;

    // host answer state; the answer stands for one cycle only
    // and is idle zero otherwise
    oit_pkg::oit_rsp_s rsp_q;
    oit_pkg::oit_rsp_s rsp_d;

    // expiry: last tick of a running count, or a zero preload at once.
    // the expiry flag is registered, so the pulse trails the last tick by a
    // cycle; the interval is still exactly preload ticks long, and a
    // zero preload expires at once instead of wrapping through 2^24
    always_comb begin
        expire = 1'b0;
        if (countdown_run_bit_q) begin
            if (count_q == '0) begin
                expire = 1'b1; // see [RULE10]
            end else if (tick && count_q == oit_pkg::PRELOAD_W'(1)) begin
                expire = 1'b1; // see [RULE10]
            end
        end
    end

    // register next values; a host write wins over a same-cycle expiry.
    // the write is the newer intent, so a restart or stop issued on the
    // expiry cycle is never undone by the self-clear of the run bit
    always_comb begin
        countdown_run_bit_d = countdown_run_bit_q;
        countdown_preload_d = countdown_preload_q;
        alternate_session_countdown_d = alternate_session_countdown_q;
        if (expire) begin
            countdown_run_bit_d = 1'b0; // see [RULE4]
        end
        if (ctrl_wr) begin
            countdown_run_bit_d = wr_run; // see [RULE2] see [RULE3]
            countdown_preload_d = preload_of(i_cmd.data); // see [RULE5]
        end
        if (alt_wr) begin
            alternate_session_countdown_d = i_cmd.data; // see [RULE8]
        end
    end

    // counter next value: load on start, hold when stopped;
    // a stop keeps the live count so it shows how far the timer got
    always_comb begin
        count_d = count_q;
        if (start) begin
            count_d = preload_of(i_cmd.data); // see [RULE2]
        end else if (stop) begin
            count_d = count_q; // see [RULE3]
        end else if (countdown_run_bit_q && tick && count_q != '0) begin
            // one unit per 0.01 ms tick, up to 167.772 s at full scale
            count_d = count_q - oit_pkg::PRELOAD_W'(1); // see [RULE6] see [RULE7]
        end
    end

    // expiry event and gated interrupt; a control write (start or stop) in the same cycle cancels.
    // the event itself is never gated by the enable, so status logic sees every
    // expiry even while the interrupt enable is off
    always_comb begin
        expired_d = expire && !ctrl_wr; // see [RULE3]
        irq_d = expire && !ctrl_wr
            && i_irq_enable_reg[oit_pkg::IRQ_EN_BIT]; // see [RULE9]
    end

    // control readback: reserved bits 30..24 always read as zero
    logic [oit_pkg::DATA_W-1:0] ctrl_word;
    assign ctrl_word = {countdown_run_bit_q, {oit_pkg::RSVD_W{1'b0}},
                        countdown_preload_q}; // see [RULE4]

    // host read answers, one cycle after the command;
    // unknown codes fall through and leave the answer idle
    always_comb begin
        rsp_d.valid = 1'b0;
        rsp_d.data = oit_pkg::RD_IDLE;
        if (ctrl_rd) begin
            rsp_d.valid = 1'b1;
            rsp_d.data = ctrl_word; // see [RULE1] see [RULE4]
        end else if (alt_rd) begin
            rsp_d.valid = 1'b1;
            rsp_d.data = alternate_session_countdown_q; // see [RULE8]
        end
    end

    // register file; only these words are visible to the host,
    // the live count is shown on its own output
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            countdown_run_bit_q <= 1'b0;
            countdown_preload_q <= oit_pkg::PRELOAD_RST; // see [RULE5]
            alternate_session_countdown_q <= oit_pkg::ALT_RST;
        end else begin
            countdown_run_bit_q <= countdown_run_bit_d;
            countdown_preload_q <= countdown_preload_d;
            alternate_session_countdown_q <= alternate_session_countdown_d;
        end
    end

    // counter and event flops; reset clears the count so no stale
    // interval survives a device reset
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            count_q <= '0; // see [RULE10]
            expired_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            count_q <= count_d;
            expired_q <= expired_d;
            irq_q <= irq_d;
        end
    end

    // answer flops; the answer pulse lasts exactly one cycle
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rsp_q.valid <= 1'b0;
            rsp_q.data <= oit_pkg::RD_IDLE;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    // outputs straight from flops, with no logic between
    // register and port
    assign o_rsp = rsp_q;
    assign o_running = countdown_run_bit_q;
    assign o_count = count_q;
    assign o_expired = expired_q;
    assign o_expiry_irq = irq_q;

endmodule : oit_interval_timer

`default_nettype wire

// >>> sim/oit_timer_assertions.sv
/* checker for the countdown timer ports.
   assumes binding onto oit_interval_timer, one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module oit_timer_assertions (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // host side
    input wire oit_pkg::oit_cmd_s i_cmd,
    input wire oit_pkg::oit_rsp_s o_rsp,
    input wire logic [31:0] i_irq_enable_reg,
    // status
    input wire logic o_running,
    input wire logic [23:0] o_count,
    input wire logic o_expired,
    input wire logic o_expiry_irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    // decoded reads and control writes
    logic rd_c;
    logic wr_c;
    assign rd_c = i_cmd.valid && (i_cmd.code == 8'h6a || i_cmd.code == 8'h6c);
    assign wr_c = i_cmd.valid && i_cmd.code == 8'hea;
    AST_RD_ANS: assert property (rd_c |=> o_rsp.valid)
        else $error("read not answered");
    AST_NO_ANS: assert property (!rd_c |=> !o_rsp.valid)
        else $error("answer without read");
    AST_START: assert property (wr_c && i_cmd.data[31] |=>
        o_running && o_count == $past(i_cmd.data[23:0]))
        else $error("start did not load");
    AST_STOP: assert property (wr_c && !i_cmd.data[31] |=>
        !o_running && !o_expired ##1 !o_expired)
        else $error("stop did not halt");
    AST_SELF_CLR: assert property (o_expired |->
        !o_running && $past(o_running) && o_count == 24'h000000)
        else $error("expiry without clearing run");
    AST_RSVD: assert property (o_rsp.valid &&
        $past(i_cmd.code) == 8'h6a |-> o_rsp.data[30:24] == 7'h00)
        else $error("reserved bits not zero");
    AST_IRQ: assert property (o_expiry_irq ==
        (o_expired && $past(i_irq_enable_reg[10])))
        else $error("irq not gated by enable");
    AST_STEP: assert property (o_running && $past(o_running) &&
        !$past(wr_c) |-> o_count == $past(o_count) ||
        o_count == $past(o_count) - 24'h000001)
        else $error("count moved by more than one");
    AST_HOLD: assert property (o_running && !$past(wr_c) &&
        o_count != $past(o_count) |=> $stable(o_count) [*8])
        else $error("ticks too close");
endmodule : oit_timer_assertions

bind oit_interval_timer oit_timer_assertions chk_i (.i_clock(i_clock),
    .i_srst(i_srst), .i_cmd(i_cmd), .o_rsp(o_rsp),
    .i_irq_enable_reg(i_irq_enable_reg), .o_running(o_running),
    .o_count(o_count), .o_expired(o_expired), .o_expiry_irq(o_expiry_irq));
`default_nettype wire

// >>> sim/oit_host_model.sv
/* host processor model: issues command codes, samples read answers.
   assumes answers come one cycle after the command. */
`timescale 1ns/100ps
`default_nettype none
module oit_host_model (
    // clock
    input wire logic i_clock,
    // command port
    output oit_pkg::oit_cmd_s o_cmd,
    input wire oit_pkg::oit_rsp_s i_rsp,
    output logic [31:0] o_irq_en
);
    initial begin
        o_cmd = '0;
        o_irq_en = 32'h00000000;
    end
    // one command for one cycle; data scrambled once dropped
    task automatic issue(input logic [7:0] c, input logic [31:0] d);
        @(posedge i_clock);
        #1 o_cmd = '{valid: 1'b1, code: c, data: d};
        @(posedge i_clock);
        #1 o_cmd = '{valid: 1'b0, code: ~c, data: ~d};
    endtask : issue
    // answer sampled in the cycle after the command
    task automatic rd(input logic [7:0] c, output logic [31:0] d);
        issue(c, 32'h00000000);
        d = i_rsp.valid ? i_rsp.data : 'x;
    endtask : rd
endmodule : oit_host_model
`default_nettype wire

// >>> sim/test_oit_interval_timer.sv
/* bench for the countdown timer: register access and expiry timing.
   assumes the host model issues every command. */
`timescale 1ns/100ps
`default_nettype none
module test_oit_interval_timer;
    localparam int TICK = 2000; // 0.01 ms in 5 ns cycles
    logic i_clock = 1'b0;
    logic i_srst = 1'b1;
    oit_pkg::oit_cmd_s cmd;
    oit_pkg::oit_rsp_s rsp;
    logic [31:0] en;
    logic [31:0] rdv;
    logic run;
    logic expd;
    logic irq;
    logic [23:0] cnt;
    int n_errors = 0;
    int compares = 0;
    int n;
    // 200 mhz clock
    always #2.5 i_clock = ~i_clock;
    oit_host_model host (.i_clock(i_clock), .o_cmd(cmd), .i_rsp(rsp),
        .o_irq_en(en));
    oit_interval_timer dut (.i_clock(i_clock), .i_srst(i_srst),
        .i_cmd(cmd), .o_rsp(rsp), .i_irq_enable_reg(en),
        .o_running(run), .o_count(cnt), .o_expired(expd),
        .o_expiry_irq(irq));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic complete_run();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    // bounded wait for the expiry pulse
    task automatic wait_exp(input int lim);
        n = 0;
        while (expd !== 1'b1) begin
            if (n == lim) begin
                n_errors++;
                complete_run();
            end
            @(posedge i_clock);
            #1;
            n++;
        end
    endtask : wait_exp
    // start a countdown and time it to the expiry pulse
    task automatic timed(input logic [23:0] pre, input logic ie);
        host.o_irq_en = {21'h000000, ie, 10'h000};
        host.issue(8'hea, {8'h80, pre});
        chk(cnt, pre);
        wait_exp(pre * TICK + 10);
        // the expiry pulse is registered one edge after the last tick
        chk(n, pre * TICK + 1);
        chk({expd, irq}, {1'b1, ie});
        host.rd(8'h6a, rdv);
        chk(rdv, {8'h00, pre});
    endtask : timed
    initial begin
        repeat (5) @(posedge i_clock);
        #1 i_srst = 1'b0;
        host.rd(8'h6a, rdv);
        chk(rdv, 32'h00000000);
        host.rd(8'h6c, rdv);
        chk(rdv, 32'h00000000);
        host.issue(8'hec, 32'ha5a55a5a);
        host.rd(8'h6c, rdv);
        chk(rdv, 32'ha5a55a5a);
        host.issue(8'hea, 32'h7f000123);
        host.rd(8'h6a, rdv);
        chk(rdv, 32'h00000123);
        timed(24'h000002, 1'b1);
        timed(24'h000001, 1'b0);
        // stop mid-count, then watch past the old expiry
        host.issue(8'hea, 32'h80000001);
        host.issue(8'hea, 32'h00000001);
        n = 0;
        repeat (2 * TICK) begin
            @(posedge i_clock);
            #1;
            n += int'(expd);
        end
        chk(n, 0);
        // full preload loads, then steps down once per tick
        host.issue(8'hea, 32'h80ffffff);
        chk(cnt, 24'hffffff);
        repeat (TICK + 1) @(posedge i_clock);
        #1 chk(cnt, 24'hfffffe);
        host.issue(8'hea, 32'h00000000);
        host.issue(8'he0, 32'h80000005);
        chk(run, 1'b0);
        // zero preload expires on the next edge
        host.issue(8'hea, 32'h80000000);
        @(posedge i_clock);
        #1 chk({expd, run}, 2'b10);
        // reset in mid-count clears counter and registers
        host.issue(8'hea, 32'h80000010);
        i_srst = 1'b1;
        repeat (2) @(posedge i_clock);
        #1 i_srst = 1'b0;
        chk({run, cnt}, 25'h0000000);
        host.rd(8'h6a, rdv);
        chk(rdv, 32'h00000000);
        complete_run();
    end
endmodule : test_oit_interval_timer
`default_nettype wire
